// [core/ufc_top.sv]
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "ufc_cfg.svh"
module ufc_top #(
   parameter int DEPTH = 64
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   // Register port
   input  wire ufc_pkg::ufc_addr_t addr_i,
   input  wire ufc_pkg::ufc_word_t wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output ufc_pkg::ufc_word_t     rdata_o,
   // Framing logic side
   input  wire logic [1:0]        char_len_i,
   input  wire logic              tx_active_i,
   input  wire logic              rx_active_i,
   output ufc_pkg::ufc_byte_t     tx_data_o,
   output logic                   tx_valid_o,
   input  wire logic              tx_ready_i,
   input  wire ufc_pkg::ufc_byte_t rx_data_i,
   input  wire logic              rx_valid_i,
   output logic                   baud_tick_o,
   // Modem line and interrupt
   output logic                   request_to_send_n_out_o,
   output logic                   irq_o
);
   import ufc_pkg::*;

   localparam int LW = $clog2(DEPTH) + 1;
   typedef logic [LW-1:0] ufc_lvl_t;

   ufc_fifo_if #(.W(8), .LW(LW)) txf ();
   ufc_fifo_if #(.W(8), .LW(LW)) rxf ();

   ufc_fifo #(.W(8), .DEPTH(DEPTH)) u_txf (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .f      (txf)
   );

   ufc_fifo #(.W(8), .DEPTH(DEPTH)) u_rxf (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .f      (rxf)
   );

   logic [7:0] div_q;
   logic [5:0] fd_thr_q;
   logic [5:0] tx_lvl_q;
   logic [5:0] rx_lvl_q;
   logic       auto_flow_control_enable_q;
   logic       rts_bit_q;
   ufc_irq_t   isr_q;
   ufc_irq_t   imask_q;
   ufc_word_t  rdata_q;
   ufc_byte_t  tx_data_q;
   logic       tx_valid_q;
   logic [7:0] baud_cnt_q;
   logic       baud_tick_q;
   logic       rts_auto_q;
   logic       rts_n_q;
   logic       irq_q;
   logic       rx_trig_q;
   logic       tx_empty_q;

   // Offsets are relative to the instance base; the fabric strips the base.
   logic sel_rxl;
   logic sel_mctl;
   logic sel_data;
   logic sel_div;
   logic sel_fd;
   logic sel_txl;
   logic sel_isr;
   logic sel_imask;

   assign sel_rxl   = (addr_i == `UFC_OFF_RX_TRIG);
   assign sel_mctl  = (addr_i == `UFC_OFF_MCTL);
   assign sel_data  = (addr_i == `UFC_OFF_DATA);
   assign sel_div   = (addr_i == `UFC_OFF_DIV);
   assign sel_fd    = (addr_i == `UFC_OFF_FDELAY);
   assign sel_txl   = (addr_i == `UFC_OFF_TX_TRIG);
   assign sel_isr   = (addr_i == `UFC_OFF_ISR);
   assign sel_imask = (addr_i == `UFC_OFF_IMASK);

   // Queue levels and the flags derived from them.
   ufc_lvl_t tx_free;
   ufc_lvl_t tx_need;
   logic     tx_nfull;
   logic     tx_trig;
   logic     rx_trig;
   logic     fd_en;
   logic     fd_hit;

   assign tx_free  = ufc_lvl_t'(DEPTH) - txf.level;
   // Code 00 reserves two bytes so a paired write never overflows.
   assign tx_need  = (char_len_i == 2'b00) ? ufc_lvl_t'(2) : ufc_lvl_t'(1);
   assign tx_nfull = (tx_free < tx_need);
   assign tx_trig  = (tx_lvl_q != '0) && (txf.level >= ufc_lvl_t'(tx_lvl_q));
   assign rx_trig  = (rx_lvl_q != '0) && (rxf.level >= ufc_lvl_t'(rx_lvl_q));
   assign fd_en    = (fd_thr_q >= `UFC_FD_HYST);
   assign fd_hit   = fd_en && (rxf.level >= ufc_lvl_t'(fd_thr_q));

   ufc_word_t status;
   always_comb begin
      status                   = '0;
      status[`UFC_ST_TX_NFULL] = tx_nfull;
      status[`UFC_ST_TX_TRIG]  = tx_trig;
      status[`UFC_ST_FDELAY]   = fd_hit;
      status[`UFC_ST_TX_ACT]   = tx_active_i;
      status[`UFC_ST_RX_ACT]   = rx_active_i;
      status[`UFC_ST_TX_FULL]  = txf.full;
      status[`UFC_ST_TX_EMPTY] = txf.empty;
      status[`UFC_ST_RX_FULL]  = rxf.full;
      status[`UFC_ST_RX_EMPTY] = rxf.empty;
      status[`UFC_ST_RX_TRIG]  = rx_trig;
   end

   // The data port pushes the transmit queue and pops the receive queue.
   assign txf.push  = wr_i && sel_data;
   assign txf.wdata = wdata_i[7:0];
   assign rxf.pop   = rd_i && sel_data;
   assign rxf.push  = rx_valid_i;
   assign rxf.wdata = rx_data_i;

   // A one-entry output register keeps the transmit stream on flip-flops.
   logic tx_load;
   assign tx_load = !txf.empty && (!tx_valid_q || tx_ready_i);
   assign txf.pop = tx_load;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_valid_q <= 1'b0;
         tx_data_q  <= 8'h00;
      end else if (tx_load) begin
         tx_valid_q <= 1'b1;
         tx_data_q  <= txf.rdata;
      end else if (tx_ready_i) begin
         tx_valid_q <= 1'b0;
      end
   end

   // Configuration registers.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_q                      <= `UFC_RST_DIV;
         fd_thr_q                   <= `UFC_RST_FDELAY;
         tx_lvl_q                   <= `UFC_RST_TX_TRIG;
         rx_lvl_q                   <= `UFC_RST_RX_TRIG;
         auto_flow_control_enable_q <= `UFC_RST_AFC;
         rts_bit_q                  <= 1'b0;
         imask_q                    <= '0;
      end else if (wr_i) begin
         // Divider values below the minimum are dropped, not clamped.
         if (sel_div && (wdata_i[7:0] >= `UFC_DIV_MIN)) begin
            div_q <= wdata_i[7:0];
         end
         if (sel_fd) begin
            fd_thr_q <= wdata_i[5:0];
         end
         if (sel_txl) begin
            tx_lvl_q <= wdata_i[5:0];
         end
         if (sel_rxl) begin
            rx_lvl_q <= wdata_i[5:0];
         end
         if (sel_mctl) begin
            auto_flow_control_enable_q <= wdata_i[`UFC_MC_AFC];
            rts_bit_q                  <= wdata_i[`UFC_MC_RTS];
         end
         if (sel_imask) begin
            imask_q <= wdata_i[3:0];
         end
      end
   end

   // Sticky events; a new event in the clearing cycle wins over the clear.
   ufc_irq_t ev;
   ufc_irq_t clr;
   always_comb begin
      ev                    = '0;
      ev[`UFC_IRQ_RX_TRIG]  = rx_trig && !rx_trig_q;
      ev[`UFC_IRQ_RX_OVR]   = rx_valid_i && rxf.full;
      ev[`UFC_IRQ_TX_OVR]   = txf.push && txf.full;
      ev[`UFC_IRQ_TX_EMPTY] = txf.empty && !tx_empty_q;
      clr                   = (wr_i && sel_isr) ? wdata_i[3:0] : '0;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         isr_q      <= '0;
         irq_q      <= 1'b0;
         rx_trig_q  <= 1'b0;
         tx_empty_q <= 1'b1;
      end else begin
         isr_q      <= (isr_q & ~clr) | ev;
         irq_q      <= |(isr_q & imask_q);
         rx_trig_q  <= rx_trig;
         tx_empty_q <= txf.empty;
      end
   end

   // Read data stand in the cycle after the strobe only.
   ufc_word_t rd_d;
   always_comb begin
      rd_d = '0;
      case (1'b1)
         sel_rxl:   rd_d = {26'h0, rx_lvl_q};
         sel_mctl:  rd_d = {26'h0, auto_flow_control_enable_q, 3'h0, rts_bit_q, 1'b0};
         `UFC_OFF_STATUS == addr_i: rd_d = status;
         sel_data:  rd_d = rxf.empty ? '0 : {24'h0, rxf.rdata};
         sel_div:   rd_d = {24'h0, div_q};
         sel_fd:    rd_d = {26'h0, fd_thr_q};
         sel_txl:   rd_d = {26'h0, tx_lvl_q};
         sel_isr:   rd_d = {28'h0, isr_q};
         sel_imask: rd_d = {28'h0, imask_q};
         default:   rd_d = '0;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rd_i ? rd_d : '0;
      end
   end

   // Baud enable; the divider never holds less than four, so no short period.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         baud_cnt_q  <= 8'h00;
         baud_tick_q <= 1'b0;
      end else if (baud_cnt_q >= div_q - 8'h01) begin
         baud_cnt_q  <= 8'h00;
         baud_tick_q <= 1'b1;
      end else begin
         baud_cnt_q  <= baud_cnt_q + 8'h01;
         baud_tick_q <= 1'b0;
      end
   end

   // Flow delay: deassert at the threshold, reassert four words below it.
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rts_auto_q <= 1'b0;
      end else if (!fd_en) begin
         rts_auto_q <= 1'b0;
      end else if (rxf.level == ufc_lvl_t'(fd_thr_q)) begin
         rts_auto_q <= 1'b1;
      end else if (rxf.level + ufc_lvl_t'(`UFC_FD_HYST) <= ufc_lvl_t'(fd_thr_q)) begin
         rts_auto_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rts_n_q <= 1'b0;
      end else if (auto_flow_control_enable_q) begin
         rts_n_q <= rts_auto_q;
      end else begin
         rts_n_q <= !rts_bit_q;
      end
   end

   assign rdata_o                 = rdata_q;
   assign tx_data_o               = tx_data_q;
   assign tx_valid_o              = tx_valid_q;
   assign baud_tick_o             = baud_tick_q;
   assign request_to_send_n_out_o = rts_n_q;
   assign irq_o                   = irq_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic rd_st;
   assign rd_st = rd_i && (addr_i == `UFC_OFF_STATUS);
   property p_nfull;
      rd_st |=> rdata_o[`UFC_ST_TX_NFULL] == ($past(tx_free) < $past(tx_need));
   endproperty
   a_nfull: assert property (p_nfull)
      else $error("nearly-full bit disagrees with free space");
   property p_pair_write;
      char_len_i == 2'b00 && tx_free == ufc_lvl_t'(1) && txf.push && !txf.pop
         |-> tx_nfull ##1 txf.full;
   endproperty
   a_pair_write: assert property (p_pair_write)
      else $error("single byte write with one byte free was lost");
   property p_tx_trig;
      rd_st && tx_lvl_q != '0 |=>
         rdata_o[`UFC_ST_TX_TRIG] == ($past(txf.level) >= ufc_lvl_t'($past(tx_lvl_q)));
   endproperty
   a_tx_trig: assert property (p_tx_trig)
      else $error("transmit trigger bit wrong");
   property p_fdelay;
      rd_st |=> rdata_o[`UFC_ST_FDELAY] ==
         ($past(fd_en) && $past(rxf.level) >= ufc_lvl_t'($past(fd_thr_q)));
   endproperty
   a_fdelay: assert property (p_fdelay)
      else $error("flow-delay bit wrong");
   property p_active;
      rd_st |=> rdata_o[11:10] == {$past(tx_active_i), $past(rx_active_i)};
   endproperty
   a_active: assert property (p_active)
      else $error("machine activity bits wrong");
   property p_rx_trig_off;
      rd_st && rx_lvl_q == '0 |=> !rdata_o[`UFC_ST_RX_TRIG];
   endproperty
   a_rx_trig_off: assert property (p_rx_trig_off)
      else $error("receive trigger set while disabled");
   property p_data_read;
      rd_i && sel_data && !rxf.empty |=>
         rdata_o[7:0] == $past(rxf.rdata) && rxf.level == $past(rxf.level) - 1'b1
         + ufc_lvl_t'($past(rx_valid_i) && !$past(rxf.full));
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("data port read did not pop the receive queue");
   property p_div_ignore;
      wr_i && sel_div && wdata_i[7:0] < `UFC_DIV_MIN |=> $stable(div_q);
   endproperty
   a_div_ignore: assert property (p_div_ignore)
      else $error("divider took a value below four");
   property p_fd_off;
      (auto_flow_control_enable_q && !fd_en)[*2] |=> !request_to_send_n_out_o;
   endproperty
   a_fd_off: assert property (p_fd_off)
      else $error("request-to-send deasserted while flow delay is disabled");
   property p_fd_hit;
      (auto_flow_control_enable_q && fd_en && rxf.level == ufc_lvl_t'(fd_thr_q))
         ##1 auto_flow_control_enable_q |=> request_to_send_n_out_o;
   endproperty
   a_fd_hit: assert property (p_fd_hit)
      else $error("request-to-send not deasserted at the threshold");
   property p_manual;
      !auto_flow_control_enable_q |=> request_to_send_n_out_o == !$past(rts_bit_q);
   endproperty
   a_manual: assert property (p_manual)
      else $error("manual request-to-send not applied");
   property p_hyst;
      (auto_flow_control_enable_q && fd_en
         && rxf.level + ufc_lvl_t'(`UFC_FD_HYST) <= ufc_lvl_t'(fd_thr_q))
         ##1 auto_flow_control_enable_q |=> !request_to_send_n_out_o;
   endproperty
   a_hyst: assert property (p_hyst)
      else $error("request-to-send not reasserted below the threshold");
   c_rts_up:  cover property ($rose(request_to_send_n_out_o));
   c_tx_ovr:  cover property (ev[`UFC_IRQ_TX_OVR]);
   c_rd_data: cover property (rd_i && sel_data && !rxf.empty);
   c_irq:     cover property ($rose(irq_o));
endmodule

// [core/ufc_cfg.svh]
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH

// Register offsets from the instance base.
`define UFC_OFF_RX_TRIG   8'h20
`define UFC_OFF_MCTL      8'h24
`define UFC_OFF_STATUS    8'h2c
`define UFC_OFF_DATA      8'h30
`define UFC_OFF_DIV       8'h34
`define UFC_OFF_FDELAY    8'h38
`define UFC_OFF_TX_TRIG   8'h44
`define UFC_OFF_ISR       8'h4c
`define UFC_OFF_IMASK     8'h50

// Live status field positions.
`define UFC_ST_TX_NFULL   14
`define UFC_ST_TX_TRIG    13
`define UFC_ST_FDELAY     12
`define UFC_ST_TX_ACT     11
`define UFC_ST_RX_ACT     10
`define UFC_ST_TX_FULL    4
`define UFC_ST_TX_EMPTY   3
`define UFC_ST_RX_FULL    2
`define UFC_ST_RX_EMPTY   1
`define UFC_ST_RX_TRIG    0

// Mode control field positions.
`define UFC_MC_AFC        5
`define UFC_MC_RTS        1

// Interrupt status bit positions.
`define UFC_IRQ_RX_TRIG   0
`define UFC_IRQ_RX_OVR    1
`define UFC_IRQ_TX_OVR    2
`define UFC_IRQ_TX_EMPTY  3

// Reset values and limits.
`define UFC_RST_DIV       8'h0f
`define UFC_RST_RX_TRIG   6'h20
`define UFC_RST_TX_TRIG   6'h20
`define UFC_RST_FDELAY    6'h00
`define UFC_RST_AFC       1'b1
`define UFC_DIV_MIN       8'h04
`define UFC_FD_HYST       6'h04

`endif

// [core/ufc_pkg.sv]
package ufc_pkg;

   typedef logic [7:0]  ufc_addr_t;
   typedef logic [31:0] ufc_word_t;
   typedef logic [7:0]  ufc_byte_t;
   typedef logic [3:0]  ufc_irq_t;

endpackage

// [core/ufc_fifo_if.sv]
`timescale 1ns/1ps
interface ufc_fifo_if #(
   parameter int W  = 8,
   parameter int LW = 7
);
   logic         push;
   logic [W-1:0] wdata;
   logic         pop;
   logic [W-1:0] rdata;
   logic [LW-1:0] level;
   logic         full;
   logic         empty;

   modport store (input push, wdata, pop, output rdata, level, full, empty);
   modport user  (output push, wdata, pop, input rdata, level, full, empty);
endinterface

// [core/ufc_fifo.sv]
`timescale 1ns/1ps
module ufc_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 64
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic nrst_i,
   // Queue ports
   ufc_fifo_if.store f
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic          do_push;
   logic          do_pop;

   // A push into a full queue or a pop from an empty one is dropped.
   assign do_push = f.push && (cnt_q != FULL_CNT);
   assign do_pop  = f.pop && (cnt_q != '0);

   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem_q[wp_q] <= f.wdata;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wp_q <= AW'(wp_q + 1'b1);
         end
         if (do_pop) begin
            rp_q <= AW'(rp_q + 1'b1);
         end
         cnt_q <= (AW+1)'(cnt_q + do_push - do_pop);
      end
   end

   assign f.rdata = mem_q[rp_q];
   assign f.level = cnt_q;
   assign f.full  = (cnt_q == FULL_CNT);
   assign f.empty = (cnt_q == '0);

   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   property p_fifo_full_holds;
      f.full && f.push && !f.pop |=> f.full && $stable(cnt_q);
   endproperty
   a_fifo_full_holds: assert property (p_fifo_full_holds)
      else $error("push into full queue changed its level");

   property p_fifo_empty_holds;
      f.empty && f.pop && !f.push |=> f.empty;
   endproperty
   a_fifo_empty_holds: assert property (p_fifo_empty_holds)
      else $error("pop from empty queue left it non-empty");
endmodule

// [bench/ufc_peer.sv]
`timescale 1ns/1ps
module ufc_peer (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   // Bench control
   input  wire logic               hold_i,
   input  wire logic               send_i,
   input  wire ufc_pkg::ufc_byte_t byte_i,
   // Design side
   input  wire ufc_pkg::ufc_byte_t tx_data_i,
   input  wire logic               tx_valid_i,
   output logic                    tx_ready_o,
   output ufc_pkg::ufc_byte_t      rx_data_o,
   output logic                    rx_valid_o
);
   import ufc_pkg::*;

   ufc_byte_t got[$];

   // A slow far side just keeps ready low, so the offered byte must stand until it is taken.
   assign tx_ready_o = !hold_i;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_valid_o <= 1'b0;
         rx_data_o  <= 8'h00;
      end else begin
         rx_valid_o <= send_i;
         // Between strobes the data lines toggle, so a stale byte is never taken for a new one.
         rx_data_o  <= send_i ? byte_i : ~rx_data_o;
      end
   end

   always @(posedge clk_i) begin
      if (nrst_i && tx_valid_i && tx_ready_o) begin
         got.push_back(tx_data_i);
      end
   end
endmodule

// [bench/uart_fifo_status_flow_ctrl_tb.sv]
`timescale 1ns/1ps
module uart_fifo_status_flow_ctrl_tb;
   import ufc_pkg::*;

   localparam int DEPTH = 64;

   logic       clk_i   = 1'b0;
   logic       nrst_i  = 1'b0;
   ufc_addr_t  addr_i  = 8'h00;
   ufc_word_t  wdata_i = 32'h0;
   ufc_word_t  rdata_o;
   ufc_word_t  v;
   logic       wr_i    = 1'b0;
   logic       rd_i    = 1'b0;
   logic       tx_act  = 1'b0;
   logic       rx_act  = 1'b0;
   logic       hold    = 1'b1;
   logic       send    = 1'b0;
   logic [1:0] clen    = 2'h0;
   ufc_byte_t  send_b  = 8'h00;
   ufc_byte_t  tx_data;
   ufc_byte_t  rx_data;
   logic       tx_valid, tx_ready, rx_valid, tick, rts_n, irq;
   int         n_fail  = 0;
   int         cmp_count = 0;
   int         cyc     = 0;
   int         tt = 32, rt = 32, fd = 0, tl = 0, rl = 0;
   logic       rts_exp = 1'b0, auto_fc = 1'b1, rts_bit = 1'b0;
   ufc_byte_t  txq[$], rxq[$];
   ufc_addr_t  ra[8] = '{8'h34, 8'h20, 8'h44, 8'h38, 8'h24, 8'h30, 8'h50, 8'h5c};
   ufc_word_t  rv[8] = '{32'hf, 32'h20, 32'h20, 32'h0, 32'h20, 32'h0, 32'h0, 32'h0};

   ufc_top #(.DEPTH(DEPTH)) i_ufc_top (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .char_len_i(clen),
      .tx_active_i(tx_act), .rx_active_i(rx_act), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
      .tx_ready_i(tx_ready), .rx_data_i(rx_data), .rx_valid_i(rx_valid), .baud_tick_o(tick),
      .request_to_send_n_out_o(rts_n), .irq_o(irq));
   ufc_peer i_ufc_peer (.clk_i(clk_i), .nrst_i(nrst_i), .hold_i(hold), .send_i(send),
      .byte_i(send_b), .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
      .rx_data_o(rx_data), .rx_valid_o(rx_valid));

   always #10 clk_i = ~clk_i;

   task automatic summarize();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end

   task automatic check(input string what, input ufc_word_t seen, input ufc_word_t exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input ufc_addr_t a, input ufc_word_t d);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rd(input ufc_addr_t a, output ufc_word_t d);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      @(posedge clk_i);
      d = rdata_o;
   endtask

   function automatic ufc_word_t exp_st();
      ufc_word_t s = 32'h0;
      s[14] = (DEPTH - tl) < ((clen == 2'h0) ? 2 : 1);
      s[13] = (tt != 0) && (tl >= tt);
      s[12] = (fd >= 4) && (rl >= fd);
      s[11] = tx_act;
      s[10] = rx_act;
      s[4]  = (tl == DEPTH);
      s[3]  = (tl == 0);
      s[2]  = (rl == DEPTH);
      s[1]  = (rl == 0);
      s[0]  = (rt != 0) && (rl >= rt);
      return s;
   endfunction

   task automatic chk_st();
      clen   <= 2'($urandom);
      tx_act <= 1'($urandom);
      rx_act <= 1'($urandom);
      repeat (2) @(posedge clk_i);
      rd(8'h2c, v);
      check("status", v, exp_st());
      if (auto_fc && fd >= 4 && rl == fd) begin
         rts_exp = 1'b1;
      end else if (auto_fc && (fd < 4 || rl + 4 <= fd)) begin
         rts_exp = 1'b0;
      end
      if (!auto_fc) begin
         rts_exp = !rts_bit;
      end
      check("rts", ufc_word_t'(rts_n), ufc_word_t'(rts_exp));
   endtask

   task automatic put(input ufc_byte_t b);
      wr(8'h30, {24'($urandom), b});
      if (txq.size() <= DEPTH) begin
         txq.push_back(b);
      end
      // While the far side stalls, the first byte sits in the output register, not the queue.
      tl = (txq.size() > 1) ? txq.size() - 1 : 0;
   endtask

   task automatic push(input ufc_byte_t b);
      send   <= 1'b1;
      send_b <= b;
      @(posedge clk_i);
      send   <= 1'b0;
      @(posedge clk_i);
      if (rl < DEPTH) begin
         rxq.push_back(b);
         rl++;
      end
   endtask

   task automatic tick_gap(input int exp);
      int n = 0;
      int k;
      // The first interval after a divider write may be partial, so two ticks are skipped.
      repeat (2) begin
         k = 0;
         while (tick !== 1'b1 && k < 600) begin
            @(posedge clk_i);
            k++;
         end
         @(posedge clk_i);
      end
      while (tick !== 1'b1 && n < 600) begin
         @(posedge clk_i);
         n++;
      end
      check("baud gap", ufc_word_t'(n + 1), ufc_word_t'(exp));
   endtask

   initial begin
      void'($urandom(32'h1aba));
      repeat (8) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      foreach (ra[i]) begin
         rd(ra[i], v);
         check("reset value", v, rv[i]);
      end
      chk_st();
      // Software writes the status word back exactly as read, unused bits untouched.
      rd(8'h2c, v);
      wr(8'h2c, v);
      chk_st();
      tick_gap(15);
      wr(8'h34, 32'h3);
      rd(8'h34, v);
      check("divider", v, 32'hf);
      wr(8'h34, 32'h4);
      tick_gap(4);
      wr(8'h34, 32'hff);
      tick_gap(255);
      tt = 1 + $urandom % 63;
      wr(8'h44, ufc_word_t'(tt));
      wr(8'h50, 32'h4);
      for (int i = 0; i < DEPTH + 2; i++) begin
         // Code 00 while one byte is free: the single-byte write must still land.
         if (i == DEPTH) begin
            clen <= 2'h0;
         end
         put(8'($urandom));
         chk_st();
      end
      rd(8'h4c, v);
      check("tx events", v & 32'hc, 32'hc);
      check("irq", ufc_word_t'(irq), 32'h1);
      wr(8'h4c, 32'h4);
      repeat (2) @(posedge clk_i);
      check("irq clear", ufc_word_t'(irq), 32'h0);
      for (int k = 0; k < 3000 && i_ufc_peer.got.size() < txq.size(); k++) begin
         hold <= 1'($urandom);
         @(posedge clk_i);
      end
      hold <= 1'b1;
      check("tx count", ufc_word_t'(i_ufc_peer.got.size()), ufc_word_t'(txq.size()));
      foreach (txq[i]) begin
         check("tx byte", ufc_word_t'(i_ufc_peer.got[i]), ufc_word_t'(txq[i]));
      end
      tl = 0;
      tt = 0;
      wr(8'h44, 32'h0);
      chk_st();
      rt = 1 + $urandom % 63;
      fd = 4 + $urandom % 60;
      wr(8'h20, ufc_word_t'(rt));
      wr(8'h38, ufc_word_t'(fd));
      for (int i = 0; i <= DEPTH; i++) begin
         push(8'($urandom));
         chk_st();
      end
      rd(8'h4c, v);
      check("rx events", v & 32'h3, 32'h3);
      check("irq masked", ufc_word_t'(irq), 32'h0);
      while (rxq.size() > 0) begin
         rd(8'h30, v);
         check("rx byte", v, {24'h0, rxq.pop_front()});
         rl--;
         chk_st();
      end
      rd(8'h30, v);
      check("empty read", v, 32'h0);
      // Both trigger functions off: level zero and a threshold too small for hysteresis.
      rt = 0;
      fd = 3;
      wr(8'h20, 32'h0);
      wr(8'h38, 32'h3);
      repeat (4) begin
         push(8'($urandom));
         chk_st();
      end
      // Manual mode at a level equal to the threshold: the software bit must win.
      auto_fc = 1'b0;
      fd = 4;
      rts_bit = 1'b1;
      wr(8'h38, 32'h4);
      wr(8'h24, 32'h2);
      rd(8'h24, v);
      check("mode ctrl", v, 32'h2);
      chk_st();
      rts_bit = 1'b0;
      wr(8'h24, 32'h0);
      chk_st();
      auto_fc = 1'b1;
      wr(8'h24, 32'h20);
      chk_st();
      summarize();
   end
endmodule
